/* rtl/nag_defines.vh */
// constants for the nonvolatile access guard
`ifndef NAG_DEFINES_VH
`define NAG_DEFINES_VH
`define NAG_AW 16
`define NAG_DW 14
`define NAG_EAW 8
`define NAG_EDW 8
`define NAG_PROG_SIZE 16'h2000
`define NAG_UID_BASE 16'h8000
`define NAG_UID_LAST 16'h8003
`define NAG_WP_OFF 2'h3
`define NAG_WP_HALF 2'h2
`define NAG_WP_QUART 2'h1
`define NAG_WP_ALL 2'h0
`define NAG_WP_END_HALF 16'h1000
`define NAG_WP_END_QUART 16'h0800
`define NAG_WP_END_ALL 16'h2000
`define NAG_ST_IDLE 2'h1
`define NAG_ST_LIVE 2'h2
`endif

/* rtl/nag_sync.v */
// two-flop synchroniser for pin-side levels
`timescale 1ns/10ps
`default_nettype none
module nag_sync #(
    parameter W = 1
) (
    input wire clk_i, // clock
    input wire rst_n, // active-low reset
    input wire [W-1:0] d_i, // asynchronous level
    output reg [W-1:0] q_o // synchronised level
);
    reg [W-1:0] meta;
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            q_o <= {W{1'b0}};
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

/* rtl/nag_wp_region.v */
// self-write region check from the size field
`timescale 1ns/10ps
`default_nettype none
`include "nag_defines.vh"
module nag_wp_region (
    input wire [1:0] size_i, // self_write_guard_size
    input wire [15:0] addr_i, // target program address
    output wire blocked_o // address lies in guarded region
);
    // region always starts at address zero
    function [15:0] wp_end;
        input [1:0] s;
        begin
            case (s)
                `NAG_WP_HALF: wp_end = `NAG_WP_END_HALF;
                `NAG_WP_QUART: wp_end = `NAG_WP_END_QUART;
                `NAG_WP_ALL: wp_end = `NAG_WP_END_ALL;
                default: wp_end = 16'h0000;
            endcase
        end
    endfunction
    assign blocked_o = (addr_i < wp_end(size_i));
endmodule
`default_nettype wire

/* rtl/nag_guard.v */
// nonvolatile access guard top
//
// Contract
// - the external guard settings never block or alter the cpu's own memory accesses.
// - program and eeprom guards act independently from their own settings.
// - with prog guard low, external program writes drop and reads give zero.
// - cpu program reads pass regardless of any guard or protect setting.
// - cpu self-writes depend only on the write-protect setting.
// - with eeprom guard low, external eeprom writes drop and reads give zero.
// - cpu eeprom reads pass regardless of the eeprom guard setting.
// - a two-bit field sizes the self-write protected region.
// - self-writes inside the region are suppressed, outside they pass.
// - user id words 8000h-8003h stay readable and writable in normal run.
`timescale 1ns/10ps
`default_nettype none
`include "nag_defines.vh"
module nag_guard (
    input wire clk_i, // 200 MHz clock
    input wire rst_n_i, // async active-low reset
    input wire prog_ext_guard_n_i, // config: low guards program memory
    input wire eeprom_ext_guard_n_i, // config: low guards eeprom
    input wire [1:0] self_write_guard_size_i, // config: wp size field
    input wire ext_prog_rd_i, // external program read, pin side
    input wire ext_prog_wr_i, // external program write, pin side
    input wire [15:0] ext_prog_addr_i, // external program address
    input wire [13:0] ext_prog_wdata_i, // external program write data
    input wire ext_ee_rd_i, // external eeprom read, pin side
    input wire ext_ee_wr_i, // external eeprom write, pin side
    input wire [7:0] ext_ee_addr_i, // external eeprom address
    input wire [7:0] ext_ee_wdata_i, // external eeprom write data
    input wire cpu_prog_rd_i, // cpu program read
    input wire cpu_prog_wr_i, // cpu self-write
    input wire [15:0] cpu_prog_addr_i, // cpu program address
    input wire [13:0] cpu_prog_wdata_i, // cpu self-write data
    input wire cpu_ee_rd_i, // cpu eeprom read
    input wire cpu_ee_wr_i, // cpu eeprom write
    input wire [7:0] cpu_ee_addr_i, // cpu eeprom address
    input wire [7:0] cpu_ee_wdata_i, // cpu eeprom write data
    input wire [13:0] mem_prog_rdata_i, // program array read data
    input wire [7:0] mem_ee_rdata_i, // eeprom array read data
    output reg mem_prog_rd_o, // program array read strobe
    output reg mem_prog_wr_o, // program array write strobe
    output reg [15:0] mem_prog_addr_o, // program array address
    output reg [13:0] mem_prog_wdata_o, // program array write data
    output reg mem_ee_rd_o, // eeprom array read strobe
    output reg mem_ee_wr_o, // eeprom array write strobe
    output reg [7:0] mem_ee_addr_o, // eeprom array address
    output reg [7:0] mem_ee_wdata_o, // eeprom array write data
    output reg [13:0] ext_prog_rdata_o, // external program read data
    output reg ext_prog_rvalid_o, // external program read valid
    output reg [7:0] ext_ee_rdata_o, // external eeprom read data
    output reg ext_ee_rvalid_o, // external eeprom read valid
    output reg [13:0] cpu_prog_rdata_o, // cpu program read data
    output reg cpu_prog_rvalid_o, // cpu program read valid
    output reg [7:0] cpu_ee_rdata_o, // cpu eeprom read data
    output reg cpu_ee_rvalid_o, // cpu eeprom read valid
    output reg cpu_wr_refused_o, // self-write dropped by protection
    output reg ext_wr_refused_o, // external write dropped by guard
    output reg cfg_live_o // settings latched, guard active
);
    reg rst_meta;
    reg rst_n;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // pin-side strobes and fields cross in through two flops
    wire [49:0] ext_raw;
    wire [49:0] ext_s;
    assign ext_raw = {ext_prog_rd_i, ext_prog_wr_i, ext_prog_addr_i,
        ext_prog_wdata_i, ext_ee_rd_i, ext_ee_wr_i, ext_ee_addr_i,
        ext_ee_wdata_i};
    nag_sync #(.W(50)) u_sync (
        .clk_i(clk_i),
        .rst_n(rst_n),
        .d_i(ext_raw),
        .q_o(ext_s)
    );
    wire s_prd = ext_s[49];
    wire s_pwr = ext_s[48];
    wire [15:0] s_paddr = ext_s[47:32];
    wire [13:0] s_pwdata = ext_s[31:18];
    wire s_erd = ext_s[17];
    wire s_ewr = ext_s[16];
    wire [7:0] s_eaddr = ext_s[15:8];
    wire [7:0] s_ewdata = ext_s[7:0];

    // edge detect so a held pin strobe counts once; the request acts one
    // cycle after the synced edge so every address and data bit has settled
    wire [3:0] strb_s = {s_prd, s_pwr, s_erd, s_ewr};
    wire [3:0] strb_take;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_strb
            reg held;
            reg take;
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    held <= 1'b0;
                    take <= 1'b0;
                end else begin
                    held <= strb_s[gi];
                    take <= strb_s[gi] & ~held;
                end
            end
            assign strb_take[gi] = take;
        end
    endgenerate
    wire e_prd = strb_take[3];
    wire e_pwr = strb_take[2];
    wire e_erd = strb_take[1];
    wire e_ewr = strb_take[0];

    // configuration words load once after reset release
    reg [1:0] state;
    reg prog_guard_n;
    reg ee_guard_n;
    reg [1:0] wp_size;
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= `NAG_ST_IDLE;
            prog_guard_n <= 1'b0;
            ee_guard_n <= 1'b0;
            wp_size <= `NAG_WP_ALL;
        end else begin
            case (state)
                `NAG_ST_IDLE: begin
                    prog_guard_n <= prog_ext_guard_n_i;
                    ee_guard_n <= eeprom_ext_guard_n_i;
                    wp_size <= self_write_guard_size_i;
                    state <= `NAG_ST_LIVE;
                end
                `NAG_ST_LIVE: state <= `NAG_ST_LIVE;
                default: state <= `NAG_ST_IDLE;
            endcase
        end
    end
    wire live = (state == `NAG_ST_LIVE);

    wire cpu_in_region;
    nag_wp_region u_wp (
        .size_i(wp_size),
        .addr_i(cpu_prog_addr_i),
        .blocked_o(cpu_in_region)
    );
    // id words sit outside the array region and stay writable
    wire cpu_uid = (cpu_prog_addr_i >= `NAG_UID_BASE) &&
        (cpu_prog_addr_i <= `NAG_UID_LAST);
    wire cpu_wr_ok = cpu_prog_wr_i & (cpu_uid | ~cpu_in_region);

    // cpu owns the array port when it asks; a colliding pin request is lost
    wire cpu_p = cpu_prog_rd_i | cpu_prog_wr_i;
    wire cpu_e = cpu_ee_rd_i | cpu_ee_wr_i;
    wire ext_p_wr_ok = e_pwr & prog_guard_n & ~cpu_p;
    wire ext_e_wr_ok = e_ewr & ee_guard_n & ~cpu_e;

    reg prd_ext_q;
    reg prd_cpu_q;
    reg prd_zero_q;
    reg prd_ext_d;
    reg prd_cpu_d;
    reg prd_zero_d;
    reg erd_ext_q;
    reg erd_cpu_q;
    reg erd_zero_q;
    reg erd_ext_d;
    reg erd_cpu_d;
    reg erd_zero_d;
    // each port has its own process so one guard never steers the other
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mem_prog_rd_o <= 1'b0;
            mem_prog_wr_o <= 1'b0;
            mem_prog_addr_o <= 16'h0000;
            mem_prog_wdata_o <= 14'h0000;
            prd_ext_q <= 1'b0;
            prd_cpu_q <= 1'b0;
            prd_zero_q <= 1'b0;
            cpu_wr_refused_o <= 1'b0;
        end else begin
            mem_prog_rd_o <= 1'b0;
            mem_prog_wr_o <= 1'b0;
            prd_ext_q <= 1'b0;
            prd_cpu_q <= 1'b0;
            prd_zero_q <= 1'b0;
            cpu_wr_refused_o <= live & cpu_prog_wr_i & ~cpu_wr_ok;
            if (live && cpu_p) begin
                mem_prog_rd_o <= cpu_prog_rd_i;
                mem_prog_wr_o <= cpu_wr_ok;
                mem_prog_addr_o <= cpu_prog_addr_i;
                mem_prog_wdata_o <= cpu_prog_wdata_i;
                prd_cpu_q <= cpu_prog_rd_i;
            end else if (live && (e_prd || e_pwr)) begin
                mem_prog_rd_o <= e_prd & prog_guard_n;
                mem_prog_wr_o <= ext_p_wr_ok;
                mem_prog_addr_o <= s_paddr;
                mem_prog_wdata_o <= s_pwdata;
                prd_ext_q <= e_prd & prog_guard_n;
                prd_zero_q <= e_prd & ~prog_guard_n;
            end
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mem_ee_rd_o <= 1'b0;
            mem_ee_wr_o <= 1'b0;
            mem_ee_addr_o <= 8'h00;
            mem_ee_wdata_o <= 8'h00;
            erd_ext_q <= 1'b0;
            erd_cpu_q <= 1'b0;
            erd_zero_q <= 1'b0;
        end else begin
            mem_ee_rd_o <= 1'b0;
            mem_ee_wr_o <= 1'b0;
            erd_ext_q <= 1'b0;
            erd_cpu_q <= 1'b0;
            erd_zero_q <= 1'b0;
            if (live && cpu_e) begin
                mem_ee_rd_o <= cpu_ee_rd_i;
                mem_ee_wr_o <= cpu_ee_wr_i;
                mem_ee_addr_o <= cpu_ee_addr_i;
                mem_ee_wdata_o <= cpu_ee_wdata_i;
                erd_cpu_q <= cpu_ee_rd_i;
            end else if (live && (e_erd || e_ewr)) begin
                mem_ee_rd_o <= e_erd & ee_guard_n;
                mem_ee_wr_o <= ext_e_wr_ok;
                mem_ee_addr_o <= s_eaddr;
                mem_ee_wdata_o <= s_ewdata;
                erd_ext_q <= e_erd & ee_guard_n;
                erd_zero_q <= e_erd & ~ee_guard_n;
            end
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_wr_refused_o <= 1'b0;
            cfg_live_o <= 1'b0;
        end else begin
            cfg_live_o <= live;
            ext_wr_refused_o <= live & ((e_pwr & ~prog_guard_n) |
                (e_ewr & ~ee_guard_n));
        end
    end

    // array data arrives the cycle after its strobe, so the request flags
    // wait one more stage before the data is taken
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prd_ext_d <= 1'b0;
            prd_cpu_d <= 1'b0;
            prd_zero_d <= 1'b0;
            ext_prog_rdata_o <= 14'h0000;
            ext_prog_rvalid_o <= 1'b0;
            cpu_prog_rdata_o <= 14'h0000;
            cpu_prog_rvalid_o <= 1'b0;
        end else begin
            prd_ext_d <= prd_ext_q;
            prd_cpu_d <= prd_cpu_q;
            prd_zero_d <= prd_zero_q;
            ext_prog_rvalid_o <= prd_ext_d | prd_zero_d;
            cpu_prog_rvalid_o <= prd_cpu_d;
            if (prd_ext_d)
                ext_prog_rdata_o <= mem_prog_rdata_i;
            else if (prd_zero_d)
                ext_prog_rdata_o <= 14'h0000;
            if (prd_cpu_d)
                cpu_prog_rdata_o <= mem_prog_rdata_i;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            erd_ext_d <= 1'b0;
            erd_cpu_d <= 1'b0;
            erd_zero_d <= 1'b0;
            ext_ee_rdata_o <= 8'h00;
            ext_ee_rvalid_o <= 1'b0;
            cpu_ee_rdata_o <= 8'h00;
            cpu_ee_rvalid_o <= 1'b0;
        end else begin
            erd_ext_d <= erd_ext_q;
            erd_cpu_d <= erd_cpu_q;
            erd_zero_d <= erd_zero_q;
            ext_ee_rvalid_o <= erd_ext_d | erd_zero_d;
            cpu_ee_rvalid_o <= erd_cpu_d;
            if (erd_ext_d)
                ext_ee_rdata_o <= mem_ee_rdata_i;
            else if (erd_zero_d)
                ext_ee_rdata_o <= 8'h00;
            if (erd_cpu_d)
                cpu_ee_rdata_o <= mem_ee_rdata_i;
        end
    end
endmodule
`default_nettype wire

/* verification/nag_mem_model.sv */
// program and eeprom arrays standing behind the guard
`timescale 1ns/10ps
`default_nettype none
module nag_mem_model (
    input wire logic clk_i, // clock
    input wire logic p_rd_i, // prog read
    input wire logic p_wr_i, // prog write
    input wire logic [15:0] p_addr_i, // prog address
    input wire logic [13:0] p_wdata_i, // prog data
    output logic [13:0] p_rdata_o = 14'h0, // prog read data
    input wire logic e_rd_i, // ee read
    input wire logic e_wr_i, // ee write
    input wire logic [7:0] e_addr_i, // ee address
    input wire logic [7:0] e_wdata_i, // ee data
    output logic [7:0] e_rdata_o = 8'h0 // ee read data
);
    logic [13:0] prog [0:16'hFFFF];
    logic [7:0] ee [0:255];
    // data lives one cycle only; it toggles after so a late grab fails
    always @(posedge clk_i) begin
        if (p_wr_i)
            prog[p_addr_i] <= p_wdata_i;
        if (e_wr_i)
            ee[e_addr_i] <= e_wdata_i;
        p_rdata_o <= p_rd_i ? prog[p_addr_i] : ~p_rdata_o;
        e_rdata_o <= e_rd_i ? ee[e_addr_i] : ~e_rdata_o;
    end
endmodule
`default_nettype wire

/* verification/nag_guard_asserts.sv */
// port checker for the access guard
`timescale 1ns/10ps
`default_nettype none
module nag_guard_asserts (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic prog_ext_guard_n_i, // guard
    input wire logic eeprom_ext_guard_n_i, // guard
    input wire logic [1:0] self_write_guard_size_i, // size
    input wire logic cpu_prog_rd_i, // strobe
    input wire logic cpu_prog_wr_i, // strobe
    input wire logic [15:0] cpu_prog_addr_i, // address
    input wire logic cpu_ee_rd_i, // strobe
    input wire logic cpu_ee_wr_i, // strobe
    input wire logic mem_prog_rd_o, // strobe
    input wire logic mem_prog_wr_o, // strobe
    input wire logic mem_ee_rd_o, // strobe
    input wire logic mem_ee_wr_o, // strobe
    input wire logic cpu_prog_rvalid_o, // valid
    input wire logic cpu_ee_rvalid_o, // valid
    input wire logic ext_prog_rvalid_o, // valid
    input wire logic [13:0] ext_prog_rdata_o, // data
    input wire logic ext_ee_rvalid_o, // valid
    input wire logic [7:0] ext_ee_rdata_o, // data
    input wire logic cpu_wr_refused_o, // pulse
    input wire logic cfg_live_o // live
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire [1:0] sz = self_write_guard_size_i;
    // code 3 gives a zero limit, so no address falls inside
    wire [15:0] lim = sz == 2'h3 ? 16'h0 : sz == 2'h2 ? 16'h1000 :
        sz == 2'h1 ? 16'h0800 : 16'h2000;
    wire in_wp = cpu_prog_addr_i < lim;
    wire live = cfg_live_o;
    a_cpu_prog_rd: assert property (
        live && cpu_prog_rd_i |=> mem_prog_rd_o ##2 cpu_prog_rvalid_o)
        else $error("cpu program read not served");
    a_cpu_ee_rd: assert property (
        live && cpu_ee_rd_i |=> mem_ee_rd_o ##2 cpu_ee_rvalid_o)
        else $error("cpu eeprom read not served");
    a_cpu_ee_wr: assert property (
        live && cpu_ee_wr_i |=> mem_ee_wr_o)
        else $error("cpu eeprom write lost");
    a_self_wr_drop: assert property (
        live && cpu_prog_wr_i && in_wp |=> !mem_prog_wr_o && cpu_wr_refused_o)
        else $error("guarded self-write not dropped");
    a_self_wr_pass: assert property (
        live && cpu_prog_wr_i && !in_wp |=> mem_prog_wr_o && !cpu_wr_refused_o)
        else $error("free self-write dropped");
    a_prog_rd_zero: assert property (
        ext_prog_rvalid_o && !prog_ext_guard_n_i |-> ext_prog_rdata_o == 14'h0)
        else $error("guarded program read not zero");
    a_ee_rd_zero: assert property (
        ext_ee_rvalid_o && !eeprom_ext_guard_n_i |-> ext_ee_rdata_o == 8'h0)
        else $error("guarded eeprom read not zero");
    a_prog_wr_cpu: assert property (
        !prog_ext_guard_n_i && mem_prog_wr_o |-> $past(cpu_prog_wr_i))
        else $error("external program write passed guard");
    a_ee_wr_cpu: assert property (
        !eeprom_ext_guard_n_i && mem_ee_wr_o |-> $past(cpu_ee_wr_i))
        else $error("external eeprom write passed guard");
endmodule
bind nag_guard nag_guard_asserts u_chk (.*);
`default_nettype wire

/* verification/tb_nag_guard.sv */
// self-checking bench for the access guard
`timescale 1ns/10ps
`default_nettype none
module tb_nag_guard;
    logic clk_i = 1'h0;
    logic rst_n_i = 1'h0;
    logic prog_ext_guard_n_i = 1'h1;
    logic eeprom_ext_guard_n_i = 1'h1;
    logic [1:0] self_write_guard_size_i = 2'h3;
    logic ext_prog_rd_i = 1'h0, ext_prog_wr_i = 1'h0, ext_ee_rd_i = 1'h0;
    logic ext_ee_wr_i = 1'h0, cpu_prog_rd_i = 1'h0, cpu_prog_wr_i = 1'h0;
    logic cpu_ee_rd_i = 1'h0, cpu_ee_wr_i = 1'h0;
    logic [15:0] ext_prog_addr_i = 16'h0, cpu_prog_addr_i = 16'h0;
    logic [13:0] ext_prog_wdata_i = 14'h0, cpu_prog_wdata_i = 14'h0;
    logic [7:0] ext_ee_addr_i = 8'h0, ext_ee_wdata_i = 8'h0;
    logic [7:0] cpu_ee_addr_i = 8'h0, cpu_ee_wdata_i = 8'h0;
    wire [13:0] mem_prog_rdata_i, mem_prog_wdata_o;
    wire [13:0] ext_prog_rdata_o, cpu_prog_rdata_o;
    wire [7:0] mem_ee_rdata_i, mem_ee_addr_o, mem_ee_wdata_o;
    wire [7:0] ext_ee_rdata_o, cpu_ee_rdata_o;
    wire [15:0] mem_prog_addr_o;
    wire mem_prog_rd_o, mem_prog_wr_o, mem_ee_rd_o, mem_ee_wr_o;
    wire ext_prog_rvalid_o, ext_ee_rvalid_o, cpu_prog_rvalid_o;
    wire cpu_ee_rvalid_o, cpu_wr_refused_o, ext_wr_refused_o, cfg_live_o;
    int n_errors = 0;
    int n_tests = 0;
    int n_cref = 0;
    int n_xref = 0;
    int c;
    int n0;
    nag_guard DUT (.*);
    nag_mem_model u_mem (.clk_i(clk_i), .p_rd_i(mem_prog_rd_o),
        .p_wr_i(mem_prog_wr_o), .p_addr_i(mem_prog_addr_o),
        .p_wdata_i(mem_prog_wdata_o), .p_rdata_o(mem_prog_rdata_i),
        .e_rd_i(mem_ee_rd_o), .e_wr_i(mem_ee_wr_o), .e_addr_i(mem_ee_addr_o),
        .e_wdata_i(mem_ee_wdata_o), .e_rdata_o(mem_ee_rdata_i));
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_cref <= n_cref + (cpu_wr_refused_o === 1'h1);
        n_xref <= n_xref + (ext_wr_refused_o === 1'h1);
    end
    task wrap_up;
        $display("checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task check(input string what, input logic [13:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task boot(input logic gp, ge, input logic [1:0] sz);
        int i;
        rst_n_i <= 1'h0;
        prog_ext_guard_n_i <= gp;
        eeprom_ext_guard_n_i <= ge;
        self_write_guard_size_i <= sz;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'h1;
        for (i = 0; i < 20 && cfg_live_o !== 1'h1; i++) @(posedge clk_i);
        if (i == 20) begin
            n_errors++;
            wrap_up;
        end
    endtask
    // one access a call; the cpu strobe stands for exactly one cycle
    task cpu(input bit ee, wr, input logic [15:0] a, input logic [13:0] d);
        @(posedge clk_i);
        {cpu_ee_rd_i, cpu_ee_wr_i} <= ee ? {!wr, wr} : 2'h0;
        {cpu_prog_rd_i, cpu_prog_wr_i} <= ee ? 2'h0 : {!wr, wr};
        {cpu_prog_addr_i, cpu_prog_wdata_i} <= {a, d};
        {cpu_ee_addr_i, cpu_ee_wdata_i} <= {a[7:0], d[7:0]};
        @(posedge clk_i);
        {cpu_prog_rd_i, cpu_prog_wr_i, cpu_ee_rd_i, cpu_ee_wr_i} <= 4'h0;
    endtask
    // pin strobes pass a synchroniser: held 3 cycles, then 3 low at least
    task ext(input bit ee, wr, input logic [15:0] a, input logic [13:0] d);
        @(posedge clk_i);
        {ext_ee_rd_i, ext_ee_wr_i} <= ee ? {!wr, wr} : 2'h0;
        {ext_prog_rd_i, ext_prog_wr_i} <= ee ? 2'h0 : {!wr, wr};
        {ext_prog_addr_i, ext_prog_wdata_i} <= {a, d};
        {ext_ee_addr_i, ext_ee_wdata_i} <= {a[7:0], d[7:0]};
        repeat (3) @(posedge clk_i);
        {ext_prog_rd_i, ext_prog_wr_i, ext_ee_rd_i, ext_ee_wr_i} <= 4'h0;
        if (wr)
            repeat (4) @(posedge clk_i);
    endtask
    task get(input bit x, ee, input logic [13:0] exp);
        int i;
        logic v;
        v = 1'h0;
        for (i = 0; i < 10 && v !== 1'h1; i++) begin
            @(posedge clk_i);
            v = x ? (ee ? ext_ee_rvalid_o : ext_prog_rvalid_o) :
                (ee ? cpu_ee_rvalid_o : cpu_prog_rvalid_o);
        end
        if (v !== 1'h1) begin
            n_errors++;
            wrap_up;
        end
        check("read data", x ? (ee ? {6'h0, ext_ee_rdata_o} : ext_prog_rdata_o)
            : (ee ? {6'h0, cpu_ee_rdata_o} : cpu_prog_rdata_o), exp);
    endtask
    task t_open;
        boot(1'h1, 1'h1, 2'h3);
        cpu(0, 1, 16'h0010, 14'h15A5);
        cpu(0, 0, 16'h0010, 14'h0);
        get(0, 0, 14'h15A5);
        ext(0, 0, 16'h0010, 14'h0);
        get(1, 0, 14'h15A5);
        ext(0, 1, 16'h0020, 14'h0ABC);
        cpu(0, 0, 16'h0020, 14'h0);
        get(0, 0, 14'h0ABC);
        ext(1, 1, 16'h0005, 14'h003C);
        cpu(1, 0, 16'h0005, 14'h0);
        get(0, 1, 14'h003C);
    endtask
    task t_guards;
        boot(1'h0, 1'h1, 2'h3);
        n0 = n_xref;
        ext(0, 1, 16'h0010, 14'h0F0F);
        check("ext refusals", 14'(n_xref - n0), 14'h1);
        ext(0, 0, 16'h0010, 14'h0);
        get(1, 0, 14'h0);
        cpu(0, 0, 16'h0010, 14'h0);
        get(0, 0, 14'h15A5);
        cpu(0, 1, 16'h0030, 14'h0123);
        cpu(0, 0, 16'h0030, 14'h0);
        get(0, 0, 14'h0123);
        ext(1, 0, 16'h0005, 14'h0);
        get(1, 1, 14'h003C);
        boot(1'h1, 1'h0, 2'h3);
        ext(1, 1, 16'h0005, 14'h00AA);
        ext(1, 0, 16'h0005, 14'h0);
        get(1, 1, 14'h0);
        cpu(1, 0, 16'h0005, 14'h0);
        get(0, 1, 14'h003C);
        cpu(1, 1, 16'h0006, 14'h005A);
        cpu(1, 0, 16'h0006, 14'h0);
        get(0, 1, 14'h005A);
        ext(0, 0, 16'h0010, 14'h0);
        get(1, 0, 14'h15A5);
    endtask
    task t_wp;
        logic [15:0] lim;
        for (c = 0; c < 3; c++) begin
            lim = c == 0 ? 16'h2000 : c == 1 ? 16'h0800 : 16'h1000;
            boot(1'h1, 1'h1, c[1:0]);
            n0 = n_cref;
            cpu(0, 1, lim - 16'h1, 14'h1111);
            cpu(0, 1, lim, 14'h2222);
            cpu(0, 1, 16'h8001, 14'h3333);
            cpu(0, 0, lim, 14'h0);
            get(0, 0, 14'h2222);
            cpu(0, 0, 16'h8001, 14'h0);
            get(0, 0, 14'h3333);
            check("cpu refusals", 14'(n_cref - n0), 14'h1);
        end
    endtask
    initial begin
        t_open;
        t_guards;
        t_wp;
        wrap_up;
    end
endmodule
`default_nettype wire
